// [pkg/ssbwm_pkg.sv]
package ssbwm_pkg;

  // ==========================================================================
  // Lane and bus geometry
  // ==========================================================================
  localparam int LANE_W = 9;
  localparam int LANES_X18 = 2;
  localparam int LANES_MAX = 4;
  localparam int DATA_W_MAX = LANES_MAX * LANE_W;
  localparam int ADDR_W_X18 = 20;
  localparam int ADDR_W_MAX = 20;

  // ==========================================================================
  // Encodings
  // ==========================================================================
  localparam logic BEAT0 = 1'h0;
  localparam logic BEAT1 = 1'h1;
  localparam logic DIR_WRITE = 1'h0;
  localparam logic DIR_READ = 1'h1;
  localparam logic LANE_WRITES = 1'h0;

  // ==========================================================================
  // Posted burst queue
  // ==========================================================================
  localparam int FIFO_DEPTH = 8;
  // Entries that may still be in the capture pipeline when a load is taken.
  localparam int FIFO_SLACK = 3;

  typedef enum logic {
    ST_IDLE,
    ST_RSP_WAIT
  } ssbwm_core_state_e;

  // One loaded burst: direction, base address, both beats and their masks.
  typedef struct packed {
    logic dir;
    logic [ADDR_W_MAX-1:0] addr;
    logic [DATA_W_MAX-1:0] d0;
    logic [DATA_W_MAX-1:0] d1;
    logic [LANES_MAX-1:0] m0_n;
    logic [LANES_MAX-1:0] m1_n;
  } ssbwm_burst_s;

  localparam int BURST_W = $bits(ssbwm_burst_s);

endpackage

// [hw/ssbwm_sync.sv]
`timescale 1ns/100ps
module ssbwm_sync
  import ssbwm_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  // ==========================================================================
  // Two-stage synchroniser; the first stage feeds only the second.
  // ==========================================================================
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule

// [hw/ssbwm_async_fifo.sv]
`timescale 1ns/100ps
module ssbwm_async_fifo
  import ssbwm_pkg::*;
#(
  parameter int WIDTH = BURST_W,
  parameter int DEPTH = FIFO_DEPTH,
  parameter int SLACK = FIFO_SLACK
) (
  input wire logic wr_clk,
  input wire logic wr_reset_n,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic rd_clk,
  input wire logic rd_reset_n,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [WIDTH-1:0] rd_data
);

  // ==========================================================================
  // Storage and gray-coded pointers
  // ==========================================================================
  localparam int AW = $clog2(DEPTH);
  localparam int PW = AW + 1;

  logic [WIDTH-1:0] store [DEPTH];
  logic [PW-1:0] wbin, wgray, rbin, rgray, rgray_w, wgray_r;
  logic [PW-1:0] next_wbin, next_rbin, used_w;
  logic push, pop;

  function automatic logic [PW-1:0] gray2bin(input logic [PW-1:0] g);
    logic [PW-1:0] b;
    b = g;
    for (int i = PW - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  // Ready keeps SLACK entries free so that bursts already in flight fit. A
  // burst that was granted room is stored whenever the queue is not full,
  // since ready may have dropped by the time it arrives.
  assign used_w = wbin - gray2bin(rgray_w);
  assign wr_ready = used_w <= PW'(DEPTH - SLACK);
  assign push = wr_valid && used_w != PW'(DEPTH);
  assign next_wbin = wbin + PW'(1);
  assign rd_valid = rgray != wgray_r;
  assign pop = rd_valid && rd_ready;
  assign next_rbin = rbin + PW'(1);
  assign rd_data = store[rbin[AW-1:0]];

  always_ff @(posedge wr_clk) begin
    if (push) begin
      store[wbin[AW-1:0]] <= wr_data;
    end
  end

  always_ff @(posedge wr_clk or negedge wr_reset_n) begin
    if (!wr_reset_n) begin
      wbin <= '0;
      wgray <= '0;
    end else if (push) begin
      wbin <= next_wbin;
      wgray <= next_wbin ^ (next_wbin >> 1);
    end
  end

  always_ff @(posedge rd_clk or negedge rd_reset_n) begin
    if (!rd_reset_n) begin
      rbin <= '0;
      rgray <= '0;
    end else if (pop) begin
      rbin <= next_rbin;
      rgray <= next_rbin ^ (next_rbin >> 1);
    end
  end

  AST_NO_LOST_PUSH: assert property (
    @(posedge wr_clk) disable iff (!wr_reset_n) wr_valid |-> used_w != PW'(DEPTH)
  ) else $error("Burst pushed while the queue was full.");

  ssbwm_sync #(.WIDTH(PW)) u_rptr_sync (.clk(wr_clk), .reset_n(wr_reset_n), .d(rgray), .q(rgray_w));
  ssbwm_sync #(.WIDTH(PW)) u_wptr_sync (.clk(rd_clk), .reset_n(rd_reset_n), .d(wgray), .q(wgray_r));

endmodule

// [hw/ssbwm_top.sv]
// Contract
// - Two-lane build: select 0 covers bits 8:0, select 1 covers 17:9; low writes.
// - Two-lane build: both selects low writes all eighteen bits of the beat.
// - Two-lane build: both selects high writes nothing; the word stays unchanged.
// - Four-lane build: selects map to 8:0, 17:9, 26:18, 35:27; low writes.
// - Four-lane build: all four selects high suppresses the beat entirely.
// - Beat one captured on positive clock rise, beat two on negative clock rise.
// - Each beat's select pattern applies only to the data sampled with it.
// - After reset the device is deselected with read outputs not driven.
// - First beat goes to base word, second beat to base plus one.
// - Read beats launch on rising edges of the clock pair.
// - Write beats follow the load at the next positive then negative rise.
`timescale 1ns/100ps
module ssbwm_top
  import ssbwm_pkg::*;
#(
  parameter int LANES = LANES_X18,
  parameter int ADDR_W = ADDR_W_X18,
  parameter int QUEUE_DEPTH = FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic k_clk,
  input wire logic k_n_clk,
  input wire logic load_strobe_n,
  input wire logic dir_read,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [LANES*LANE_W-1:0] wr_data,
  input wire logic [LANES-1:0] lane_write_mask_n,
  output logic [LANES*LANE_W-1:0] rd_data,
  output logic rd_data_oe,
  output logic burst_ready,
  output logic write_commit,
  output logic core_idle
);

  // ==========================================================================
  // Derived sizes and per-domain resets
  // ==========================================================================
  localparam int DATA_W = LANES * LANE_W;
  localparam int WORDS = 2 ** (ADDR_W + 1);

  logic rst_k_n;
  logic rst_kn_n;

  // Each link domain gets its own reset whose release is aligned to that clock.
  ssbwm_sync #(.WIDTH(1)) u_rst_k (.clk(k_clk), .reset_n(reset_n), .d(1'h1), .q(rst_k_n));
  ssbwm_sync #(.WIDTH(1)) u_rst_kn (.clk(k_n_clk), .reset_n(reset_n), .d(1'h1), .q(rst_kn_n));

  // ==========================================================================
  // Link side: address load and first beat on the positive input clock
  // ==========================================================================
  logic ld_valid, ld_dir;
  logic [ADDR_W-1:0] ld_addr;
  logic beat_valid, beat_dir;
  logic [ADDR_W-1:0] beat_addr;
  logic [DATA_W-1:0] beat_d0;
  logic [LANES-1:0] beat_m0;
  logic [DATA_W-1:0] neg_d;
  logic [LANES-1:0] neg_m;
  logic accept;
  ssbwm_burst_s push_entry;
  logic fifo_wr_ready;

  // A load is only taken while the queue can absorb everything in flight.
  assign accept = !load_strobe_n && fifo_wr_ready;
  assign burst_ready = fifo_wr_ready;

  always_ff @(posedge k_clk or negedge rst_k_n) begin
    if (!rst_k_n) begin
      ld_valid <= 1'h0;
      ld_dir <= DIR_WRITE;
      ld_addr <= '0;
    end else begin
      ld_valid <= accept;
      ld_dir <= dir_read;
      ld_addr <= addr;
    end
  end

  // The rise after the load carries the first beat and its lane selects.
  always_ff @(posedge k_clk or negedge rst_k_n) begin
    if (!rst_k_n) begin
      beat_valid <= 1'h0;
      beat_dir <= DIR_WRITE;
      beat_addr <= '0;
      beat_d0 <= '0;
      beat_m0 <= '1;
    end else begin
      beat_valid <= ld_valid;
      beat_dir <= ld_dir;
      beat_addr <= ld_addr;
      beat_d0 <= wr_data;
      beat_m0 <= lane_write_mask_n;
    end
  end

  // ==========================================================================
  // Link side: second beat on the negative input clock
  // ==========================================================================
  // Sampling on every rise is harmless: only the copy following a loaded
  // burst's first beat is ever pushed.
  always_ff @(posedge k_n_clk or negedge rst_kn_n) begin
    if (!rst_kn_n) begin
      neg_d <= '0;
      neg_m <= '1;
    end else begin
      neg_d <= wr_data;
      neg_m <= lane_write_mask_n;
    end
  end

  // Both beats, both masks and the address enter the queue as one entry, so a
  // posted write later applies exactly the selects that came with it.
  always_comb begin
    push_entry = '0;
    push_entry.dir = beat_dir;
    push_entry.addr = ADDR_W_MAX'(beat_addr);
    push_entry.d0 = DATA_W_MAX'(beat_d0);
    push_entry.d1 = DATA_W_MAX'(neg_d);
    push_entry.m0_n = LANES_MAX'(beat_m0);
    push_entry.m1_n = LANES_MAX'(neg_m);
  end

  // ==========================================================================
  // Posted burst queue between the link and the array
  // ==========================================================================
  ssbwm_burst_s head;
  logic fifo_rd_valid, fifo_rd_ready;

  ssbwm_async_fifo #(
    .WIDTH(BURST_W),
    .DEPTH(QUEUE_DEPTH),
    .SLACK(FIFO_SLACK)
  ) u_queue (
    .wr_clk(k_clk),
    .wr_reset_n(rst_k_n),
    .wr_valid(beat_valid),
    .wr_ready(fifo_wr_ready),
    .wr_data(push_entry),
    .rd_clk(clk),
    .rd_reset_n(reset_n),
    .rd_valid(fifo_rd_valid),
    .rd_ready(fifo_rd_ready),
    .rd_data(head)
  );

  // ==========================================================================
  // Array with per-lane write masking
  // ==========================================================================
  ssbwm_core_state_e state;
  logic do_write, do_read, pop;
  logic [ADDR_W:0] idx_a0, idx_a1, idx_c0, idx_c1;
  logic [ADDR_W-1:0] chk_addr;
  wire [DATA_W-1:0] cur0, cur1, chk_rd0, chk_rd1, next_exp0, next_exp1;

  assign fifo_rd_ready = state == ST_IDLE;
  assign pop = fifo_rd_valid && fifo_rd_ready;
  assign do_write = pop && head.dir == DIR_WRITE;
  assign do_read = pop && head.dir == DIR_READ;
  assign idx_a0 = {head.addr[ADDR_W-1:0], BEAT0};
  assign idx_a1 = {head.addr[ADDR_W-1:0], BEAT1};
  assign idx_c0 = {chk_addr, BEAT0};
  assign idx_c1 = {chk_addr, BEAT1};

  // Each lane owns its own array so each has a single writer, and a masked
  // lane simply sees no write strobe instead of a read-modify-write.
  for (genvar l = 0; l < LANES; l++) begin : g_lane
    logic [LANE_W-1:0] lane_mem [WORDS];

    always_ff @(posedge clk) begin
      if (do_write && head.m0_n[l] == LANE_WRITES) begin
        lane_mem[idx_a0] <= head.d0[l*LANE_W +: LANE_W];
      end
      if (do_write && head.m1_n[l] == LANE_WRITES) begin
        lane_mem[idx_a1] <= head.d1[l*LANE_W +: LANE_W];
      end
    end

    assign cur0[l*LANE_W +: LANE_W] = lane_mem[idx_a0];
    assign cur1[l*LANE_W +: LANE_W] = lane_mem[idx_a1];
    assign chk_rd0[l*LANE_W +: LANE_W] = lane_mem[idx_c0];
    assign chk_rd1[l*LANE_W +: LANE_W] = lane_mem[idx_c1];
    assign next_exp0[l*LANE_W +: LANE_W] = head.m0_n[l] ? cur0[l*LANE_W +: LANE_W] : head.d0[l*LANE_W +: LANE_W];
    assign next_exp1[l*LANE_W +: LANE_W] = head.m1_n[l] ? cur1[l*LANE_W +: LANE_W] : head.d1[l*LANE_W +: LANE_W];
  end

  // ==========================================================================
  // Core control: write commit, read fetch and response handshake
  // ==========================================================================
  logic rsp_tog, ack_c, rsp_seen;
  logic [DATA_W-1:0] core_rd_w0, core_rd_w1;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (do_read) begin
            state <= ST_RSP_WAIT;
          end
        end
        ST_RSP_WAIT: begin
          if (ack_c == rsp_tog) begin
            state <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // The fetched pair stays put until the link echoes the toggle back, so the
  // link may copy it across domains without a data synchroniser.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rsp_tog <= 1'h0;
      core_rd_w0 <= '0;
      core_rd_w1 <= '0;
    end else if (do_read) begin
      rsp_tog <= ~rsp_tog;
      core_rd_w0 <= cur0;
      core_rd_w1 <= cur1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      write_commit <= 1'h0;
      core_idle <= 1'h1;
    end else begin
      write_commit <= do_write;
      core_idle <= !fifo_rd_valid && state == ST_IDLE;
    end
  end

  ssbwm_sync #(.WIDTH(1)) u_ack_sync (.clk(clk), .reset_n(reset_n), .d(rsp_seen), .q(ack_c));

  // ==========================================================================
  // Link side: read beats onto the output pins
  // ==========================================================================
  logic rsp_tog_k, rd_show;
  logic [DATA_W-1:0] rd_w0, rd_w1, q_p, q_n;
  logic oe_p, oe_n, tp, tn;

  ssbwm_sync #(.WIDTH(1)) u_rsp_sync (.clk(k_clk), .reset_n(rst_k_n), .d(rsp_tog), .q(rsp_tog_k));

  always_ff @(posedge k_clk or negedge rst_k_n) begin
    if (!rst_k_n) begin
      rsp_seen <= 1'h0;
      rd_show <= 1'h0;
      rd_w0 <= '0;
      rd_w1 <= '0;
    end else begin
      rsp_seen <= rsp_tog_k;
      rd_show <= rsp_tog_k != rsp_seen;
      if (rsp_tog_k != rsp_seen) begin
        rd_w0 <= core_rd_w0;
        rd_w1 <= core_rd_w1;
      end
    end
  end

  // Beat zero launches on the negative rise, beat one on the next positive rise.
  always_ff @(posedge k_n_clk or negedge rst_kn_n) begin
    if (!rst_kn_n) begin
      q_n <= '0;
      oe_n <= 1'h0;
      tn <= 1'h0;
    end else begin
      q_n <= rd_w0;
      oe_n <= rd_show;
      tn <= tp;
    end
  end

  always_ff @(posedge k_clk or negedge rst_k_n) begin
    if (!rst_k_n) begin
      q_p <= '0;
      oe_p <= 1'h0;
      tp <= 1'h0;
    end else begin
      q_p <= rd_w1;
      oe_p <= rd_show;
      tp <= ~tn;
    end
  end

  // The two toggles differ after a positive rise and agree after a negative
  // one, so the mux follows whichever edge came last without a clock-level gate.
  assign rd_data = (tp != tn) ? q_p : q_n;
  assign rd_data_oe = (tp != tn) ? oe_p : oe_n;

  // ==========================================================================
  // Check helpers and assertions
  // ==========================================================================
  logic chk_valid;
  logic [DATA_W-1:0] chk_exp0, chk_exp1, chk_d0, chk_old1;
  logic [LANES_MAX-1:0] chk_m0, chk_m1;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      chk_valid <= 1'h0;
      chk_addr <= '0;
      chk_exp0 <= '0;
      chk_exp1 <= '0;
      chk_d0 <= '0;
      chk_old1 <= '0;
      chk_m0 <= '1;
      chk_m1 <= '1;
    end else begin
      chk_valid <= do_write;
      chk_addr <= head.addr[ADDR_W-1:0];
      chk_exp0 <= next_exp0;
      chk_exp1 <= next_exp1;
      chk_d0 <= head.d0[DATA_W-1:0];
      chk_old1 <= cur1;
      chk_m0 <= head.m0_n;
      chk_m1 <= head.m1_n;
    end
  end

  AST_LANE_MERGE_BEAT0: assert property (
    @(posedge clk) disable iff (!reset_n) chk_valid |-> chk_rd0 == chk_exp0
  ) else $error("Beat zero lanes not merged as selected.");

  AST_FULL_WRITE: assert property (
    @(posedge clk) disable iff (!reset_n)
    chk_valid && chk_m0[LANES-1:0] == '0 |-> chk_rd0 == chk_d0
  ) else $error("All-lane write did not store the whole beat.");

  AST_MASKED_OFF: assert property (
    @(posedge clk) disable iff (!reset_n)
    chk_valid && &chk_m1[LANES-1:0] |-> chk_rd1 == chk_old1
  ) else $error("Fully masked beat altered the stored word.");

  AST_LANE_MERGE_BEAT1: assert property (
    @(posedge clk) disable iff (!reset_n) chk_valid |-> chk_rd1 == chk_exp1
  ) else $error("Beat one lanes not merged as selected at base plus one.");

  AST_BEAT0_CAPTURE: assert property (
    @(posedge k_clk) disable iff (!rst_k_n)
    ld_valid |=> beat_valid && beat_d0 == $past(wr_data) && beat_m0 == $past(lane_write_mask_n)
  ) else $error("First beat not captured on the rise after the load.");

  AST_WRITE_PUSH: assert property (
    @(posedge k_n_clk) disable iff (!rst_kn_n)
    beat_valid && beat_dir == DIR_WRITE |=> push_entry.d1[DATA_W-1:0] == $past(wr_data) &&
      push_entry.m1_n[LANES-1:0] == $past(lane_write_mask_n)
  ) else $error("Second beat did not reach the queue entry.");

  AST_OUT_QUIET: assert property (
    @(posedge k_clk) disable iff (!rst_k_n) !rd_show |-> !rd_data_oe
  ) else $error("Read outputs driven without a read response.");

  AST_READ_LAUNCH: assert property (
    @(posedge k_clk) disable iff (!rst_k_n) rd_show |=> oe_p && q_p == $past(rd_w1)
  ) else $error("Second read beat not launched on the next rise.");

endmodule

// [sim/ssbwm_ctrl_model.sv]
`timescale 1ns/100ps
module ssbwm_ctrl_model
  import ssbwm_pkg::*;
#(
  parameter int LANES = LANES_X18,
  parameter int ADDR_W = ADDR_W_X18
) (
  input wire logic k_clk,
  input wire logic k_n_clk,
  input wire logic burst_ready,
  input wire logic [LANES*LANE_W-1:0] rd_data,
  input wire logic rd_data_oe,
  output logic load_strobe_n,
  output logic dir_read,
  output logic [ADDR_W-1:0] addr,
  output logic [LANES*LANE_W-1:0] wr_data,
  output logic [LANES-1:0] lane_write_mask_n
);
  localparam int W = LANES * LANE_W;

  initial begin
    load_strobe_n = 1'h1;
    dir_read = DIR_READ;
    addr = '0;
    wr_data = '0;
    lane_write_mask_n = '1;
  end

  // ==========================================================================
  // Bursts
  // ==========================================================================
  // Released lines except dir_read show the inverse of their last value so stale data never looks valid.
  task automatic load_burst(input logic [ADDR_W-1:0] a, input logic dir);
    int n;
    n = 0;
    while (burst_ready !== 1'h1 && n < 100) begin
      @(negedge k_clk);
      n++;
    end
    @(posedge k_clk);
    load_strobe_n <= 1'h0;
    dir_read <= dir;
    addr <= a;
    @(posedge k_clk);
    load_strobe_n <= 1'h1;
    addr <= ~a;
  endtask

  task automatic write_burst(input logic [ADDR_W-1:0] a, input logic [W-1:0] d0, input logic [LANES-1:0] m0,
                             input logic [W-1:0] d1, input logic [LANES-1:0] m1);
    load_burst(a, DIR_WRITE);
    wr_data <= d0;
    lane_write_mask_n <= m0;
    @(posedge k_clk);
    wr_data <= d1;
    lane_write_mask_n <= m1;
    @(posedge k_n_clk);
    wr_data <= ~d1;
    lane_write_mask_n <= ~m1;
  endtask

  task automatic read_burst(input logic [ADDR_W-1:0] a, output logic [W-1:0] q0, output logic [W-1:0] q1,
                            output bit ok);
    int n;
    ok = 1'b0;
    n = 0;
    load_burst(a, DIR_READ);
    while (!ok && n < 40) begin
      @(posedge k_n_clk);
      #1;
      ok = (rd_data_oe === 1'h1);
      n++;
    end
    q0 = rd_data;
    @(posedge k_clk);
    #1;
    q1 = rd_data;
  endtask
endmodule

// [sim/ssbwm_top_tb.sv]
`timescale 1ns/100ps
module ssbwm_top_tb
  import ssbwm_pkg::*;
();
  localparam int AW = 6;
  logic clk, reset_n, k_clk, k_n_clk;
  logic ls_n_x18, dir_x18, oe_x18, rdy_x18;
  logic [AW-1:0] addr_x18;
  logic [17:0] wd_x18, rd_x18;
  logic [1:0] m_x18;
  logic ls_n_x36, dir_x36, oe_x36, rdy_x36;
  logic [AW-1:0] addr_x36;
  logic [35:0] wd_x36, rd_x36;
  logic [3:0] m_x36;
  logic wc_x18, idle_x18, wc_x36, idle_x36, k_park;
  int commits_x18 = 0;
  int commits_x36 = 0;
  int mismatches = 0;
  int checked = 0;

  // ==========================================================================
  // Clocks, instances
  // ==========================================================================
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // The link clock runs free with an odd offset so its edges never line up with clk.
  // Parking holds both link clocks high, the state that allows the quickest restart.
  initial begin
    k_clk = 1'h0;
    k_park = 1'h0;
    #13;
    forever #40 k_clk = ~k_clk | k_park;
  end
  assign k_n_clk = ~k_clk | k_park;

  // Commit pulses are counted half a clock away from the edge that launches them.
  always @(negedge clk) begin
    if (wc_x18 === 1'h1) commits_x18++;
    if (wc_x36 === 1'h1) commits_x36++;
  end

  ssbwm_top #(.LANES(LANES_X18), .ADDR_W(AW), .QUEUE_DEPTH(FIFO_DEPTH)) u_ssbwm_top (
    .clk(clk), .reset_n(reset_n), .k_clk(k_clk), .k_n_clk(k_n_clk), .load_strobe_n(ls_n_x18),
    .dir_read(dir_x18), .addr(addr_x18), .wr_data(wd_x18), .lane_write_mask_n(m_x18), .rd_data(rd_x18),
    .rd_data_oe(oe_x18), .burst_ready(rdy_x18), .write_commit(wc_x18), .core_idle(idle_x18));
  ssbwm_top #(.LANES(LANES_MAX), .ADDR_W(AW), .QUEUE_DEPTH(FIFO_DEPTH)) u_ssbwm_top_x36 (
    .clk(clk), .reset_n(reset_n), .k_clk(k_clk), .k_n_clk(k_n_clk), .load_strobe_n(ls_n_x36),
    .dir_read(dir_x36), .addr(addr_x36), .wr_data(wd_x36), .lane_write_mask_n(m_x36), .rd_data(rd_x36),
    .rd_data_oe(oe_x36), .burst_ready(rdy_x36), .write_commit(wc_x36), .core_idle(idle_x36));
  ssbwm_ctrl_model #(.LANES(LANES_X18), .ADDR_W(AW)) u_ctrl_x18 (
    .k_clk(k_clk), .k_n_clk(k_n_clk), .burst_ready(rdy_x18), .rd_data(rd_x18), .rd_data_oe(oe_x18),
    .load_strobe_n(ls_n_x18), .dir_read(dir_x18), .addr(addr_x18), .wr_data(wd_x18), .lane_write_mask_n(m_x18));
  ssbwm_ctrl_model #(.LANES(LANES_MAX), .ADDR_W(AW)) u_ctrl_x36 (
    .k_clk(k_clk), .k_n_clk(k_n_clk), .burst_ready(rdy_x36), .rd_data(rd_x36), .rd_data_oe(oe_x36),
    .load_strobe_n(ls_n_x36), .dir_read(dir_x36), .addr(addr_x36), .wr_data(wd_x36), .lane_write_mask_n(m_x36));

  // ==========================================================================
  // Access tasks
  // ==========================================================================
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [35:0] merge(input logic [35:0] old, input logic [35:0] nw, input logic [3:0] m);
    logic [35:0] r;
    for (int l = 0; l < 4; l++) begin
      r[l*9 +: 9] = m[l] ? old[l*9 +: 9] : nw[l*9 +: 9];
    end
    return r;
  endfunction

  task automatic wr(input bit sel, input logic [5:0] a, input logic [35:0] d0, input logic [3:0] m0,
                    input logic [35:0] d1, input logic [3:0] m1);
    if (sel) u_ctrl_x36.write_burst(a, d0, m0, d1, m1);
    else u_ctrl_x18.write_burst(a, d0[17:0], m0[1:0], d1[17:0], m1[1:0]);
  endtask

  task automatic rd(input bit sel, input logic [5:0] a, output logic [35:0] q0, output logic [35:0] q1,
                    output bit ok);
    logic [17:0] s0, s1;
    if (sel) begin
      u_ctrl_x36.read_burst(a, q0, q1, ok);
    end else begin
      u_ctrl_x18.read_burst(a, s0, s1, ok);
      q0 = {18'h0, s0};
      q1 = {18'h0, s1};
    end
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  // Every select code on beat one, its complement on beat two, read back at once behind the posted write.
  task automatic lane_sweep(input bit sel);
    logic [35:0] i0, i1, q0, q1, wm;
    logic [3:0] p;
    bit ok;
    wm = sel ? 36'hF_FFFF_FFFF : 36'h0_0003_FFFF;
    for (int k = 0; k < (sel ? 16 : 4); k++) begin
      p = k[3:0];
      i0 = (36'h1_2345_6789 ^ {32'h0, p}) & wm;
      i1 = (36'h9_ABCD_EF01 ^ {28'h0, p, 4'h0}) & wm;
      wr(sel, {2'h0, p}, i0, 4'h0, i1, 4'h0);
      wr(sel, {2'h0, p}, ~i0 & wm, p, ~i1 & wm, ~p);
      rd(sel, {2'h0, p}, q0, q1, ok);
      check({35'h0, ok}, 36'h1);
      if (sel) begin
        check(q0, merge(i0, ~i0 & wm, p));
        check(q1, merge(i1, ~i1 & wm, ~p));
      end else begin
        check(q0, merge(i0, ~i0 & wm, p));
        check(q1, merge(i1, ~i1 & wm, ~p));
      end
    end
  endtask

  // Top address, then a neighbour written back to back, must not disturb it.
  task automatic boundary(input bit sel);
    logic [35:0] q0, q1, wm;
    bit ok;
    wm = sel ? 36'hF_FFFF_FFFF : 36'h0_0003_FFFF;
    wr(sel, 6'h3F, 36'hA_5A5A_5A5A & wm, 4'h0, 36'h5_A5A5_A5A5 & wm, 4'h0);
    wr(sel, 6'h3E, 36'h0_F0F0_F0F0 & wm, 4'h0, 36'h0_0F0F_0F0F & wm, 4'h0);
    rd(sel, 6'h3F, q0, q1, ok);
    check({35'h0, ok}, 36'h1);
    check(q0, 36'hA_5A5A_5A5A & wm);
    check(q1, 36'h5_A5A5_A5A5 & wm);
  endtask

  task automatic results();
    if (mismatches == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    reset_n = 1'h0;
    repeat (16) @(posedge clk);
    repeat (4) @(posedge k_clk);
    @(posedge clk);
    reset_n <= 1'h1;
    repeat (4) @(posedge k_clk);
    check({35'h0, oe_x18}, 36'h0);
    check({35'h0, oe_x36}, 36'h0);
    check({34'h0, idle_x36, idle_x18}, 36'h3);
    lane_sweep(1'b0);
    lane_sweep(1'b1);
    boundary(1'b0);
    boundary(1'b1);
    repeat (20) @(posedge clk);
    check(36'(commits_x18), 36'hA);
    check(36'(commits_x36), 36'h22);
    check({34'h0, idle_x36, idle_x18}, 36'h3);
    k_park <= 1'h1;
    repeat (2) @(posedge clk);
    results();
  end

  // About 70 bursts of at most 15 link cycles each; twice that bounds a hang.
  initial begin
    #200000;
    mismatches++;
    results();
  end
endmodule
